// ---- logic/gfb_pkg.sv ----
// Shared constants for the forced-function and boot-select pin override block.
// Assumes a single 250 MHz system clock and an Avalon-MM register slave.
// Functional notes
// R01 - Forced functions apply at reset until released
// R02 - PA7 drives regulator enable as open drain
// R03 - Clearing regulator bit returns PA7 to GPIO
// R04 - PC0, PC3 pulled inputs; PC2 push-pull output
// R05 - PC4 test mode input or serial data
// R06 - Reset puts all debug pins in JTAG
// R07 - Only debug tool selects JTAG or serial-wire
// R08 - Debug disable returns four pins to GPIO
// R09 - Debug disable ignored while debug is active
// R10 - Tool reclaims port in reset, flag set
// R11 - Debug active means powerup request is high
// R12 - All listed reset sources are full resets
// R13 - Full reset loads floating input everywhere
// R14 - Floating input configuration value is 0x4
// R15 - Full reset sets regulator enable bit
// R16 - Full reset clears debug disable bit
// R17 - Boot select honoured only on pin/POR
// R18 - PA5 pulled-up input through 512-clock delay
// R19 - Sample boot select at delay end
// R20 - Resample after 3 ms in monitor
// R21 - Host holds boot select low 4 ms
// R22 - After sampling PA5 floats, level recorded
// R23 - Captured level lives in debug status
// R24 - Pads follow override source else config

package gfb_pkg;

  // Pin counts and configuration field width.
  localparam int unsigned NUM_PINS = 24;
  localparam int unsigned CFG_W = 4;

  // Pin indices: port A 0..7, port B 8..15, port C 16..23.
  localparam int unsigned PIN_PA5 = 5;
  localparam int unsigned PIN_PA7 = 7;
  localparam int unsigned PIN_PC0 = 16;
  localparam int unsigned PIN_PC2 = 18;
  localparam int unsigned PIN_PC3 = 19;
  localparam int unsigned PIN_PC4 = 20;

  // Configuration mode codes.
  localparam logic [3:0] CFG_ANALOG = 4'h0;
  localparam logic [3:0] CFG_OUT_PP = 4'h1;
  localparam logic [3:0] CFG_IN_FLOAT = 4'h4;
  localparam logic [3:0] CFG_OUT_OD = 4'h5;
  localparam logic [3:0] CFG_IN_PULL = 4'h8;
  localparam logic [3:0] CFG_ALT_PP = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hd;

  // Register byte offsets.
  localparam logic [5:0] OFS_CFG_A = 6'h00;
  localparam logic [5:0] OFS_CFG_B = 6'h04;
  localparam logic [5:0] OFS_CFG_C = 6'h08;
  localparam logic [5:0] OFS_OUT = 6'h0c;
  localparam logic [5:0] OFS_DBGCFG = 6'h10;
  localparam logic [5:0] OFS_DBGSTAT = 6'h14;

  // Field positions in the debug configuration register.
  localparam int unsigned DBGCFG_DEBUGDIS_BIT = 5;
  localparam int unsigned DBGCFG_EXTREGEN_BIT = 4;

  // Field positions in the debug status register.
  localparam int unsigned DBGSTAT_BOOTSEL_BIT = 3;
  localparam int unsigned DBGSTAT_FORCEDBG_BIT = 1;
  localparam int unsigned DBGSTAT_SWMODE_BIT = 0;

  // Reset values of the debug configuration bits.
  localparam logic EXTREGEN_RST = 1'b1;
  localparam logic DEBUGDIS_RST = 1'b0;

  // Timing: startup delay in oscillator clocks and monitor resample time.
  localparam int unsigned STARTUP_CLOCKS = 512;
  // Cycles a level needs to pass the two-flop synchroniser.
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RESAMPLE_MS = 3;
  localparam int unsigned RESAMPLE_CYCLES = RESAMPLE_MS * 1000 * 1000 * CLK_MHZ / 1000;

  // Boot sequencer states.
  typedef enum logic [1:0] {
    GFB_BOOT_HOLD,
    GFB_BOOT_WAIT_RESAMPLE,
    GFB_BOOT_DONE
  } gfb_boot_state_t;

endpackage

// ---- logic/gfb_sync2.sv ----
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes the destination clock is clk_sys; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module gfb_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Asynchronous input and synchronised output.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta_q;

  // Both stages clear on reset and then shift the level in.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ---- logic/gfb_pad_ctl.sv ----
// Per-pin pad control: turns a 4-bit mode, an output bit and a peripheral bit
// into pad output, output enable and pull controls. Purely combinational.
`timescale 1ns/100ps
`default_nettype none

module gfb_pad_ctl
  import gfb_pkg::*;
(
  // Mode and data sources.
  input wire logic [3:0] mode,
  input wire logic out_bit,
  input wire logic alt_bit,
  // Pad controls.
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up,
  output logic pull_down
);

  // Decode the mode; open drain only enables the driver to pull low.
  always_comb begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    pull_up = 1'b0;
    pull_down = 1'b0;
    unique case (mode)
      CFG_OUT_PP: begin
        pad_out = out_bit;
        pad_oe = 1'b1;
      end
      CFG_OUT_OD: begin
        pad_oe = !out_bit;
      end
      CFG_ALT_PP: begin
        pad_out = alt_bit;
        pad_oe = 1'b1;
      end
      CFG_ALT_OD: begin
        pad_oe = !alt_bit;
      end
      CFG_IN_PULL: begin
        pull_up = out_bit;
        pull_down = !out_bit;
      end
      default: begin
        // Analog, floating input and unused codes leave the pad idle.
        pad_out = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- logic/gfb_forced_pins.sv ----
// Top of the forced-function and boot-select override block.
// Assumes reset_n is the full chip reset (all sources merged outside) and that
// debug and boot pins arrive asynchronously and are synchronised here.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module gfb_forced_pins
  import gfb_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = STARTUP_CLOCKS,
  parameter int unsigned RESAMPLE_CYC = RESAMPLE_CYCLES
) (
  // Clock and full chip reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Boot-select qualifier: high when the reset came from pin or always-on POR.
  input wire logic boot_reset_source,
  // Avalon-MM register slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Debug port state from the external tool side.
  input wire logic debug_powerup_request,
  input wire logic debug_serial_wire_mode,
  input wire logic tool_attach_in_reset,
  input wire logic test_data_out,
  input wire logic debug_swdio_out,
  input wire logic debug_swdio_oe,
  // Regulator enable and peripheral outputs.
  input wire logic regulator_enable,
  input wire logic [NUM_PINS-1:0] alt_out,
  // Pad side.
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] pad_pull_up,
  output logic [NUM_PINS-1:0] pad_pull_down,
  // Synchronised pad levels and boot result.
  output logic [NUM_PINS-1:0] pin_level,
  output logic boot_monitor,
  output logic boot_done
);

  // Pin configuration fields, four bits per pin, port A in the low word.
  logic [NUM_PINS*CFG_W-1:0] cfg_q;
  // Output data bits; in pulled-input mode they pick up or down.
  logic [NUM_PINS-1:0] out_q;
  // Set while PA7 carries the regulator enable.
  logic ext_regulator_enable_bit_q;
  // Set when software has handed the four debug pins back to GPIO.
  logic debug_disable_bit_q;
  // Set when the tool claimed the port while the chip sat in reset.
  logic forced_debug_flag_q;
  // Last sampled boot-select level; reads high until a sample is taken.
  logic boot_select_captured_q;
  // Boot outcome: monitor selected, and decision made.
  logic boot_monitor_q;
  logic boot_done_q;
  // Bus wait state and registered read data.
  logic wait_q;
  logic [31:0] rdata_q;
  // Boot sequencer state and its shared cycle counter.
  gfb_boot_state_t boot_state_q;
  logic [31:0] count_q;
  // Cleared only by reset; once set, PA5 is no longer held pulled up.
  logic boot_sampled_q;

  // Synchronised pad levels.
  logic [NUM_PINS-1:0] pad_sync;
  // Debug levels after two flops: request, mode, attach in reset.
  logic [2:0] dbg_sync;
  // Decoded debug state: port in use, and serial-wire mode chosen.
  logic dbg_active;
  logic dbg_sw_mode;

  // Normal-mode pad controls from the configuration registers.
  logic [NUM_PINS-1:0] n_out;
  logic [NUM_PINS-1:0] n_oe;
  logic [NUM_PINS-1:0] n_pu;
  logic [NUM_PINS-1:0] n_pd;

  // Byte-wise write data merge helper.
  logic [31:0] wmask;

  // Decoded writes.
  logic wr_go;

  // Pad levels cross into clk_sys through two flops.
  gfb_sync2 #(.WIDTH(NUM_PINS)) u_pad_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  // The tool's levels cross the same way; bit 2 is read only at startup.
  gfb_sync2 #(.WIDTH(3)) u_dbg_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({tool_attach_in_reset, debug_serial_wire_mode, debug_powerup_request}),
    .sync_out(dbg_sync)
  );

  // Debug is active while the tool's powerup request, two flops late, is high.
  assign dbg_active = dbg_sync[0]; // see R11
  // The mode comes only from the tool; no register can change it.
  assign dbg_sw_mode = dbg_sync[1]; // see R07
  assign pin_level = pad_sync;

  // Decode each pin's configuration into normal pad controls.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pad
      gfb_pad_ctl u_pad (
        .mode(cfg_q[gi*CFG_W +: CFG_W]),
        .out_bit(out_q[gi]),
        .alt_bit(alt_out[gi]),
        .pad_out(n_out[gi]),
        .pad_oe(n_oe[gi]),
        .pull_up(n_pu[gi]),
        .pull_down(n_pd[gi])
      );
    end
  endgenerate

  // Byte enables widened to a bit mask.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // A write lands on the edge where waitrequest is low.
  assign wr_go = avs_write && !wait_q;

  // One wait state per access: waitrequest drops one cycle after the request.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      // The first cycle of a request is its one wait state; answer next.
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) ? wait_q : 1'b1;

  // Configuration fields: every pin's field loads floating input after a full chip reset.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_q <= {NUM_PINS{CFG_IN_FLOAT}}; // see R12, R13, R14
    end else if (wr_go) begin
      // Each port word merges only the bytes that are enabled.
      if (avs_address == OFS_CFG_A) begin
        cfg_q[31:0] <= (cfg_q[31:0] & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address == OFS_CFG_B) begin
        cfg_q[63:32] <= (cfg_q[63:32] & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address == OFS_CFG_C) begin
        cfg_q[95:64] <= (cfg_q[95:64] & ~wmask) | (avs_writedata & wmask);
      end
    end
  end

  // Output data register for all 24 pins.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      out_q <= '0;
    end else if (wr_go && avs_address == OFS_OUT) begin
      out_q <= (out_q & ~wmask[NUM_PINS-1:0])
        | (avs_writedata[NUM_PINS-1:0] & wmask[NUM_PINS-1:0]);
    end
  end

  // Regulator enable bit: set by reset, software may clear or set it.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ext_regulator_enable_bit_q <= EXTREGEN_RST; // see R15, R01
    end else if (wr_go && avs_address == OFS_DBGCFG && avs_byteenable[0]) begin
      ext_regulator_enable_bit_q <= avs_writedata[DBGCFG_EXTREGEN_BIT]; // see R03
    end
  end

  // Debug disable bit: cleared by reset, set refused while debug is active.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      debug_disable_bit_q <= DEBUGDIS_RST; // see R16, R06
    end else if (wr_go && avs_address == OFS_DBGCFG && avs_byteenable[0]) begin
      // Clearing is always allowed; setting only while the port is idle.
      if (!avs_writedata[DBGCFG_DEBUGDIS_BIT]) begin
        debug_disable_bit_q <= 1'b0;
      end else if (!dbg_active) begin
        debug_disable_bit_q <= 1'b1; // see R09
      end
    end
  end

  // Forced-debug flag: tool attached while the chip sat in reset. The attach
  // level passes the synchroniser first, so it is taken SYNC_STAGES counts in.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      forced_debug_flag_q <= 1'b0;
    end else if (boot_state_q == GFB_BOOT_HOLD && count_q == SYNC_STAGES) begin
      forced_debug_flag_q <= dbg_sync[2]; // see R10
    end
  end

  // Boot sequencer: startup delay, first sample, optional resample.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      boot_state_q <= GFB_BOOT_HOLD;
      count_q <= 32'h0000_0000;
      boot_sampled_q <= 1'b0;
      boot_select_captured_q <= 1'b1;
      boot_monitor_q <= 1'b0;
      boot_done_q <= 1'b0;
    end else begin
      unique case (boot_state_q)
        // Count out the startup delay, then take the first sample.
        GFB_BOOT_HOLD: begin
          if (count_q == STARTUP_CYC - 1) begin // see R18
            count_q <= 32'h0000_0000;
            boot_sampled_q <= 1'b1;
            boot_select_captured_q <= pad_sync[PIN_PA5]; // see R19, R23
            if (boot_reset_source && !pad_sync[PIN_PA5]) begin // see R17
              boot_monitor_q <= 1'b1;
              boot_state_q <= GFB_BOOT_WAIT_RESAMPLE;
            end else begin
              boot_done_q <= 1'b1;
              boot_state_q <= GFB_BOOT_DONE;
            end
          end else begin
            count_q <= count_q + 32'h0000_0001;
          end
        end
        // Monitor chosen: look again after the resample delay.
        GFB_BOOT_WAIT_RESAMPLE: begin
          if (count_q == RESAMPLE_CYC - 1) begin // see R20
            boot_monitor_q <= !pad_sync[PIN_PA5];
            boot_select_captured_q <= pad_sync[PIN_PA5];
            boot_done_q <= 1'b1;
            boot_state_q <= GFB_BOOT_DONE;
          end else begin
            count_q <= count_q + 32'h0000_0001;
          end
        end
        // Decision made; stay here until the next full reset.
        GFB_BOOT_DONE: begin
          boot_done_q <= 1'b1;
        end
      endcase
    end
  end
  assign boot_monitor = boot_monitor_q;
  assign boot_done = boot_done_q;

  // Read data mux; unmapped addresses read zero.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      unique case (avs_address)
        OFS_CFG_A: rdata_q <= cfg_q[31:0];
        OFS_CFG_B: rdata_q <= cfg_q[63:32];
        OFS_CFG_C: rdata_q <= cfg_q[95:64];
        OFS_OUT: rdata_q <= {8'h00, out_q};
        // Debug configuration: only the two defined bits read back.
        OFS_DBGCFG: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[DBGCFG_DEBUGDIS_BIT] <= debug_disable_bit_q;
          rdata_q[DBGCFG_EXTREGEN_BIT] <= ext_regulator_enable_bit_q;
        end
        // Status bits are read-only; the mode bit mirrors the tool.
        OFS_DBGSTAT: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[DBGSTAT_BOOTSEL_BIT] <= boot_select_captured_q; // see R23
          rdata_q[DBGSTAT_FORCEDBG_BIT] <= forced_debug_flag_q;
          rdata_q[DBGSTAT_SWMODE_BIT] <= dbg_sw_mode;
        end
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  // Final pad mux: forced sources win over the configuration registers.
  always_comb begin
    pad_out = n_out;
    pad_oe = n_oe;
    pad_pull_up = n_pu;
    pad_pull_down = n_pd;
    // PA7 is open drain: it sinks while the enable is low, floats when high.
    if (ext_regulator_enable_bit_q) begin // see R02, R24
      pad_out[PIN_PA7] = 1'b0;
      pad_oe[PIN_PA7] = !regulator_enable;
      pad_pull_up[PIN_PA7] = 1'b0;
      pad_pull_down[PIN_PA7] = 1'b0;
    end
    if (!debug_disable_bit_q) begin // see R08, R24
      // PC0 is the test reset input, pulled up.
      pad_out[PIN_PC0] = 1'b0;
      pad_oe[PIN_PC0] = 1'b0;
      pad_pull_up[PIN_PC0] = 1'b1; // see R04
      pad_pull_down[PIN_PC0] = 1'b0;
      // PC2 pushes the test data out.
      pad_out[PIN_PC2] = test_data_out;
      pad_oe[PIN_PC2] = 1'b1;
      pad_pull_up[PIN_PC2] = 1'b0;
      pad_pull_down[PIN_PC2] = 1'b0;
      // PC3 is the test data input, pulled up.
      pad_out[PIN_PC3] = 1'b0;
      pad_oe[PIN_PC3] = 1'b0;
      pad_pull_up[PIN_PC3] = 1'b1;
      pad_pull_down[PIN_PC3] = 1'b0;
      // PC4 follows the mode that the tool has chosen.
      pad_pull_down[PIN_PC4] = 1'b0;
      if (dbg_sw_mode) begin // see R05
        pad_out[PIN_PC4] = debug_swdio_out;
        pad_oe[PIN_PC4] = debug_swdio_oe;
        pad_pull_up[PIN_PC4] = 1'b0;
      end else begin
        pad_out[PIN_PC4] = 1'b0;
        pad_oe[PIN_PC4] = 1'b0;
        pad_pull_up[PIN_PC4] = 1'b1;
      end
    end
    // PA5 stays a pulled-up input until boot select has been sampled.
    if (!boot_sampled_q) begin // see R18, R22
      pad_out[PIN_PA5] = 1'b0;
      pad_oe[PIN_PA5] = 1'b0;
      pad_pull_up[PIN_PA5] = 1'b1;
      pad_pull_down[PIN_PA5] = 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- sim/gfb_forced_pins_props.sv ----
// Checker for the forced pin override block.
// Assumes it sees only the top module ports; bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module gfb_forced_pins_props
  import gfb_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = 16,
  parameter int unsigned RESAMPLE_CYC = 40
) (
  // Clock, reset and bus.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic boot_reset_source,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Debug side.
  input wire logic debug_powerup_request,
  input wire logic debug_serial_wire_mode,
  input wire logic test_data_out,
  input wire logic debug_swdio_oe,
  input wire logic regulator_enable,
  // Pads and boot result.
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] pad_pull_up,
  input wire logic boot_monitor,
  input wire logic boot_done
);
  // Cycles since reset release, saturating so it never wraps.
  logic [31:0] cyc_q;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cyc_q <= 32'h0;
    end else if (cyc_q != 32'hffff) begin
      cyc_q <= cyc_q + 32'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // A request is held one cycle, then answered.
  sequence s_access;
    (avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_ACCESS: assert property ($rose(avs_read || avs_write) |-> s_access)
    else $error("bus answer not one cycle after request");
  AST_PA7_RESET: assert property (
    $rose(reset_n) |-> pad_oe[PIN_PA7] == !regulator_enable && !pad_out[PIN_PA7])
    else $error("PA7 not regulator enable after reset");
  AST_DEBUG_RESET: assert property (
    $rose(reset_n) |-> pad_pull_up[PIN_PC0] && pad_pull_up[PIN_PC3] && pad_pull_up[PIN_PC4]
      && !pad_oe[PIN_PC4] && pad_oe[PIN_PC2] && pad_out[PIN_PC2] == test_data_out)
    else $error("debug pins not forced after reset");
  AST_PA5_PULL: assert property (
    cyc_q + 2 < STARTUP_CYC |-> pad_pull_up[PIN_PA5] && !pad_oe[PIN_PA5])
    else $error("PA5 not pulled up during startup");
  AST_BOOT_TIME: assert property (
    $rose(boot_done) |-> (cyc_q + 3 >= STARTUP_CYC && cyc_q <= STARTUP_CYC + 3) ||
      (cyc_q + 3 >= STARTUP_CYC + RESAMPLE_CYC && cyc_q <= STARTUP_CYC + RESAMPLE_CYC + 3))
    else $error("boot decided at wrong time");
  AST_BOOT_SOURCE: assert property ($rose(boot_monitor) |-> boot_reset_source)
    else $error("monitor chosen after other reset");
  AST_DIS_REFUSED: assert property (
    avs_write && !avs_waitrequest && avs_address == OFS_DBGCFG
      && avs_writedata[DBGCFG_DEBUGDIS_BIT] && debug_powerup_request
      && $past(debug_powerup_request, 2) && pad_pull_up[PIN_PC0] && pad_oe[PIN_PC2]
      |=> (pad_pull_up[PIN_PC0] && pad_oe[PIN_PC2]) [*4])
    else $error("debug disable taken while debug active");
  AST_SWD_PC4: assert property (
    $rose(debug_serial_wire_mode) && pad_pull_up[PIN_PC0] && pad_oe[PIN_PC2]
      |-> ##3 !pad_pull_up[PIN_PC4] && pad_oe[PIN_PC4] == debug_swdio_oe)
    else $error("PC4 not serial data in serial wire mode");
endmodule
bind gfb_forced_pins gfb_forced_pins_props #(.STARTUP_CYC(STARTUP_CYC),
  .RESAMPLE_CYC(RESAMPLE_CYC)) gfb_forced_pins_props_i (.clk_sys, .reset_n,
  .boot_reset_source, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
  .debug_powerup_request, .debug_serial_wire_mode, .test_data_out, .debug_swdio_oe,
  .regulator_enable, .pad_out, .pad_oe, .pad_pull_up, .boot_monitor, .boot_done);
`default_nettype wire

// ---- sim/gfb_tool_model.sv ----
// Model of the external debug tool and regulator enable source.
// Assumes the bench turns the tool on and off after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module gfb_tool_model (
  // Clock and bench commands.
  input wire logic clk_sys,
  input wire logic tool_on,
  input wire logic swd_on,
  // Tool and regulator side of the block.
  output logic debug_powerup_request,
  output logic debug_serial_wire_mode,
  output logic tool_attach_in_reset,
  output logic test_data_out,
  output logic debug_swdio_out,
  output logic debug_swdio_oe,
  output logic regulator_enable
);
  // Changing pattern, so stale data never passes for valid data.
  logic [2:0] pat_q = 3'h0;
  always_ff @(posedge clk_sys) begin
    pat_q <= pat_q + 3'h1;
  end
  assign debug_powerup_request = tool_on;
  assign tool_attach_in_reset = tool_on;
  assign debug_serial_wire_mode = tool_on && swd_on;
  assign test_data_out = pat_q[0];
  assign debug_swdio_out = pat_q[1];
  assign debug_swdio_oe = swd_on && pat_q[2];
  assign regulator_enable = pat_q[1];
endmodule
`default_nettype wire

// ---- sim/gfb_forced_pins_tb.sv ----
// Self-checking bench for the forced pin override block.
// Assumes the checker is bound in and the tool model drives the debug side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import gfb_pkg::*;
  localparam int unsigned SU = 16;
  localparam int unsigned RS = 40;
  // Bench driven inputs.
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic boot_reset_source = 1'b1;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [NUM_PINS-1:0] pads = 24'hffffff;
  logic tool_on = 1'b0;
  logic swd_on = 1'b0;
  // Design outputs and tool signals.
  logic [31:0] avs_readdata;
  logic avs_waitrequest, boot_monitor, boot_done, debug_powerup_request, debug_serial_wire_mode;
  logic tool_attach_in_reset, test_data_out, debug_swdio_out, debug_swdio_oe, regulator_enable;
  logic [NUM_PINS-1:0] pad_out, pad_oe, pad_pull_up, pad_pull_down, pin_level;
  logic [31:0] rd;
  int fails = 0;
  int total_checks = 0;
  // Free running 250 MHz clock.
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  gfb_forced_pins #(.STARTUP_CYC(SU), .RESAMPLE_CYC(RS)) gfb_forced_pins_i (.clk_sys, .reset_n,
    .boot_reset_source, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .debug_powerup_request, .debug_serial_wire_mode,
    .tool_attach_in_reset, .test_data_out, .debug_swdio_out, .debug_swdio_oe,
    .regulator_enable, .alt_out(24'h0), .pad_in(pads), .pad_out, .pad_oe, .pad_pull_up,
    .pad_pull_down, .pin_level, .boot_monitor, .boot_done);
  gfb_tool_model gfb_tool_model_i (.clk_sys, .tool_on, .swd_on, .debug_powerup_request,
    .debug_serial_wire_mode, .tool_attach_in_reset, .test_data_out, .debug_swdio_out,
    .debug_swdio_oe, .regulator_enable);
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low.
  task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Reads a register and compares it.
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Full chip reset with a boot pin level and reset source.
  task automatic do_reset(input logic pa5, input logic src);
    @(posedge clk_sys);
    pads[PIN_PA5] <= pa5;
    boot_reset_source <= src;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  // Waits for the boot decision.
  task automatic wait_boot;
    while (boot_done !== 1'b1) @(negedge clk_sys);
  endtask
  // Prints counts and verdict, then stops.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
  // Main sequence of tests.
  initial begin
    do_reset(1'b1, 1'b1);
    @(negedge clk_sys);
    check(pad_pull_up[PIN_PA5], 1'b1);
    check(pad_oe[PIN_PA7], !regulator_enable);
    check({pad_pull_up[PIN_PC0], pad_pull_up[PIN_PC3], pad_oe[PIN_PC2]}, 3'h7);
    rd_chk(OFS_CFG_A, 32'h44444444);
    rd_chk(OFS_CFG_C, 32'h44444444);
    rd_chk(OFS_DBGCFG, 32'h10);
    wait_boot();
    check(boot_monitor, 1'b0);
    check(pad_pull_up[PIN_PA5], 1'b0);
    rd_chk(OFS_DBGSTAT, 32'h8);
    $display("test 1 done");
    // The tool is active, so a disable write is dropped.
    @(posedge clk_sys);
    tool_on <= 1'b1;
    swd_on <= 1'b1;
    repeat (4) @(posedge clk_sys);
    access(1'b1, OFS_DBGCFG, 32'h30);
    access(1'b1, OFS_DBGSTAT, 32'h0);
    rd_chk(OFS_DBGCFG, 32'h10);
    rd_chk(OFS_DBGSTAT, 32'h9);
    @(negedge clk_sys);
    check(pad_oe[PIN_PC4], debug_swdio_oe);
    check(pad_pull_up[PIN_PC0], 1'b1);
    $display("test 2 done");
    // Idle tool: debug pins and PA7 go back to plain GPIO.
    @(posedge clk_sys);
    tool_on <= 1'b0;
    swd_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    access(1'b1, OFS_DBGCFG, 32'h20);
    rd_chk(OFS_DBGCFG, 32'h20);
    access(1'b1, OFS_CFG_C, 32'h44444148);
    access(1'b1, OFS_OUT, 32'h40000);
    rd_chk(6'h18, 32'h0);
    @(negedge clk_sys);
    check({pad_oe[PIN_PA7], pad_pull_up[PIN_PC0], pad_oe[PIN_PC2], pad_out[PIN_PC2]}, 4'h3);
    check(pad_pull_down[PIN_PC0], 1'b1);
    check(pin_level, pads);
    $display("test 3 done");
    // Tool attached in reset, boot pin held low throughout.
    @(posedge clk_sys);
    tool_on <= 1'b1;
    do_reset(1'b0, 1'b1);
    rd_chk(OFS_CFG_C, 32'h44444444);
    rd_chk(OFS_DBGCFG, 32'h10);
    wait_boot();
    check(boot_monitor, 1'b1);
    rd_chk(OFS_DBGSTAT, 32'h2);
    $display("test 4 done");
    // Boot pin released before the resample, then a reset of the other kind.
    @(posedge clk_sys);
    tool_on <= 1'b0;
    do_reset(1'b0, 1'b1);
    repeat (24) @(posedge clk_sys);
    pads[PIN_PA5] <= 1'b1;
    wait_boot();
    repeat (RS) @(negedge clk_sys);
    check(boot_monitor, 1'b0);
    do_reset(1'b0, 1'b0);
    wait_boot();
    check(boot_monitor, 1'b0);
    $display("test 5 done");
    complete_run();
  end
endmodule
`default_nettype wire
